// *** relay_pkg.sv ***
// Shared constants, select codes and helpers for the relay two function selector
package relay_pkg;

  // ====================
  // Widths
  // ====================
  localparam int unsigned SEL_W  = 4;              // Function select field width
  localparam int unsigned ADDR_W = 12;             // Decoded byte address bits

  // ====================
  // Register map (byte addresses, one aligned word each)
  // ====================
  localparam logic [ADDR_W-1:0] OFS_FUNC_SEL = 12'h000;  // Relay two function select
  localparam logic [ADDR_W-1:0] OFS_UPPER    = 12'h004;  // Relay upper threshold
  localparam logic [ADDR_W-1:0] OFS_LOWER    = 12'h008;  // Relay lower threshold
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h00C;  // Read-only live state

  // ====================
  // Reset values
  // ====================
  localparam logic [SEL_W-1:0] FUNC_SEL_RST = 4'h0;      // Drive running after reset
  localparam logic [31:0]      UPPER_RST    = 32'h0000_0000;
  localparam logic [31:0]      LOWER_RST    = 32'h0000_0000;

  // ====================
  // Status field positions
  // ====================
  localparam int unsigned STAT_RELAY_BIT = 0;      // Relay contact closed
  localparam int unsigned STAT_BAND_BIT  = 1;      // Hysteresis latch state
  localparam int unsigned STAT_COND_BIT  = 2;      // Selected condition, unregistered

  // ====================
  // AHB-Lite encodings
  // ====================
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  // ====================
  // Function select codes
  // ====================
  typedef enum logic [SEL_W-1:0] {
    FUNC_DRIVE_RUNNING  = 4'b0000,
    FUNC_DRIVE_HEALTHY  = 4'b0001,
    FUNC_AT_TARGET      = 4'b0010,
    FUNC_FREQ_NONZERO   = 4'b0011,
    FUNC_SPEED_LIMIT    = 4'b0100,
    FUNC_CURRENT_LIMIT  = 4'b0101,
    FUNC_TORQUE_LIMIT   = 4'b0110,
    FUNC_ANALOG2_LIMIT  = 4'b0111,
    FUNC_ASSIST_PUMP    = 4'b1000,
    FUNC_OVERRIDE       = 4'b1001,
    FUNC_MAINT_DUE      = 4'b1010,
    FUNC_AUTO_AVAILABLE = 4'b1011,
    FUNC_TRIPPED        = 4'b1100,
    FUNC_SAFETY_ENABLED = 4'b1101,
    FUNC_PID_ERR_LIMIT  = 4'b1110,
    FUNC_UNUSED         = 4'b1111
  } relay_func_type;

  // True for the selections that run through the hysteresis comparator
  function automatic logic uses_threshold(input logic [SEL_W-1:0] sel);
    uses_threshold = (sel == FUNC_SPEED_LIMIT)   || (sel == FUNC_CURRENT_LIMIT) ||
                     (sel == FUNC_TORQUE_LIMIT)  || (sel == FUNC_ANALOG2_LIMIT) ||
                     (sel == FUNC_PID_ERR_LIMIT);
  endfunction

endpackage

// *** relay_hysteresis.sv ***
// Upper/lower threshold comparator with a latched hysteresis band
module relay_hysteresis
  import relay_pkg::*;
#(
  parameter int unsigned VALUE_W = 16
) (
  input  wire logic               core_clk_i,
  input  wire logic               rstn_i,
  input  wire logic               enable_i,    // Threshold selection active
  input  wire logic               clear_i,     // Drop the latch, e.g. select rewritten
  input  wire logic [VALUE_W-1:0] value_i,     // Monitored quantity
  input  wire logic [VALUE_W-1:0] upper_i,     // Set above this
  input  wire logic [VALUE_W-1:0] lower_i,     // Release below this
  output logic                    active_d_o,  // Next latch state
  output logic                    active_q_o   // Current latch state
);

  // ====================
  // Next state
  // ====================
  logic active_q;                              // Hysteresis latch
  logic active_d;                              // Its next value

  // Between the two thresholds the latch keeps its value
  always_comb begin
    active_d = active_q;
    if (!enable_i || clear_i) begin
      active_d = 1'b0;                         // Off when not in a threshold mode
    end else if (value_i > upper_i) begin
      active_d = 1'b1;
    end else if (value_i < lower_i) begin
      active_d = 1'b0;
    end
  end

  // ====================
  // Latch register
  // ====================
  // Cleared under reset so the band starts released
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  assign active_d_o = active_d;
  assign active_q_o = active_q;

endmodule

// *** relay_condition_select.sv ***
// Combinational choice of the relay condition and of the monitored quantity
module relay_condition_select
  import relay_pkg::*;
#(
  parameter int unsigned VALUE_W = 16
) (
  input  wire logic [SEL_W-1:0]   sel_i,           // Function select
  input  wire logic               running_i,       // Output stage enabled and running
  input  wire logic               healthy_i,       // Powered and fault free
  input  wire logic               at_target_i,     // Output equals set-point
  input  wire logic               freq_nonzero_i,  // Output frequency above zero
  input  wire logic               pump_i,          // Assist pump control
  input  wire logic               override_i,      // Emergency override active
  input  wire logic               maint_i,         // Service due
  input  wire logic               auto_avail_i,    // Auto, no trip, ready
  input  wire logic               tripped_i,       // Tripped state
  input  wire logic               safety_i,        // Both safety enables and operable
  input  wire logic [VALUE_W-1:0] speed_i,
  input  wire logic [VALUE_W-1:0] current_i,
  input  wire logic [VALUE_W-1:0] torque_i,
  input  wire logic [VALUE_W-1:0] analog2_i,
  input  wire logic [VALUE_W-1:0] pid_err_i,
  output logic [VALUE_W-1:0]      monitored_o,     // Quantity for the comparator
  output logic                    cond_o           // Non-threshold condition
);

  // Only the selected source reaches either output
  always_comb begin
    monitored_o = '0;
    cond_o      = 1'b0;
    case (relay_func_type'(sel_i))
      FUNC_DRIVE_RUNNING:  cond_o = running_i;
      FUNC_DRIVE_HEALTHY:  cond_o = healthy_i;
      FUNC_AT_TARGET:      cond_o = at_target_i;
      FUNC_FREQ_NONZERO:   cond_o = freq_nonzero_i;
      FUNC_SPEED_LIMIT:    monitored_o = speed_i;
      FUNC_CURRENT_LIMIT:  monitored_o = current_i;
      FUNC_TORQUE_LIMIT:   monitored_o = torque_i;
      FUNC_ANALOG2_LIMIT:  monitored_o = analog2_i;
      FUNC_ASSIST_PUMP:    cond_o = pump_i;
      FUNC_OVERRIDE:       cond_o = override_i;
      FUNC_MAINT_DUE:      cond_o = maint_i;
      FUNC_AUTO_AVAILABLE: cond_o = auto_avail_i;
      FUNC_TRIPPED:        cond_o = tripped_i;
      FUNC_SAFETY_ENABLED: cond_o = safety_i;
      FUNC_PID_ERR_LIMIT:  monitored_o = pid_err_i;
      default:             cond_o = 1'b0;          // Unassigned code keeps relay open
    endcase
  end

endmodule

// *** relay_output_function_select.sv ***
// Relay two function selector with AHB-Lite configuration registers
//
// Summary of operation
// - Relay follows only the selected condition.
// - Threshold modes set above upper threshold.
// - Threshold modes release below lower threshold.
// - Select 0: motor output running.
// - Select 1: powered and no fault.
// - Select 2: output equals set-point frequency.
// - Select 3: output frequency above zero.
// - Select 4: monitor motor speed.
// - Select 5: monitor motor current.
// - Select 6: monitor motor torque.
// - Select 7: monitor analog input two.
// - Select 8: first assist pump control.
// - Select 9: emergency override mode running.
// - Select 10: maintenance interval expired.
// - Select 11: auto, untripped, ready.
// - Select 12: drive tripped.
// - Select 13: both safety enables, operable.
// - Contact closed while condition true.
module relay_output_function_select
  import relay_pkg::*;
#(
  parameter int unsigned VALUE_W = 16             // Width of monitored quantities
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rstn_i,
  // AHB-Lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic [31:0]             hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  // Drive status
  input  wire logic               motor_running_i,
  input  wire logic               power_ok_i,
  input  wire logic               fault_i,
  input  wire logic [VALUE_W-1:0] out_freq_i,
  input  wire logic [VALUE_W-1:0] setpoint_freq_i,
  input  wire logic [VALUE_W-1:0] motor_speed_i,
  input  wire logic [VALUE_W-1:0] motor_current_i,
  input  wire logic [VALUE_W-1:0] motor_torque_i,
  input  wire logic [VALUE_W-1:0] analog_in2_i,
  input  wire logic [VALUE_W-1:0] pid_error_i,
  input  wire logic               direct_online_assist_pump_i,
  input  wire logic               emergency_override_i,
  input  wire logic               maintenance_due_i,
  input  wire logic               auto_mode_i,
  input  wire logic               trip_active_i,
  input  wire logic               auto_ready_i,
  input  wire logic               tripped_i,
  input  wire logic [1:0]         hardware_safety_enable_i,
  input  wire logic               drive_operable_i,
  // Relay drive
  output logic                    relay_contact_closed_o
);

  // ====================
  // Elaboration check
  // ====================
  // Thresholds live in one 32-bit word, so wider quantities cannot be served
  if (VALUE_W < 1 || VALUE_W > 32) begin : g_bad_width
    $error("VALUE_W must lie between 1 and 32");
  end

  // ====================
  // Register state
  // ====================
  logic [SEL_W-1:0]   func_sel_q;                 // Relay two function select
  logic [VALUE_W-1:0] upper_q;                    // Relay upper threshold
  logic [VALUE_W-1:0] lower_q;                    // Relay lower threshold
  logic               relay_q;                    // Registered relay drive
  logic               relay_d;                    // Its next value

  // ====================
  // AHB-Lite address phase capture
  // ====================
  logic               wr_pend_q;                  // Write data phase in progress
  logic [ADDR_W-1:0]  wr_addr_q;                  // Address of that write
  logic               addr_valid;                 // Transfer taken this cycle
  logic [ADDR_W-1:0]  addr_lo;                    // Decoded part of haddr

  assign addr_lo    = haddr_i[ADDR_W-1:0];
  // Upper address bits are ignored: the slave aliases every 4 KiB
  assign addr_valid = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

  // Remember a write until its data phase completes
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (hready_i) begin
      wr_pend_q <= addr_valid && hwrite_i;
      wr_addr_q <= addr_lo;
    end
  end

  // ====================
  // Write commit
  // ====================
  logic wr_commit;                                // Write data phase ends now
  logic sel_write;                                // Select register being written

  // Zero wait state slave, so every data phase ends on the next hready
  assign wr_commit = wr_pend_q && hready_i;
  assign sel_write = wr_commit && (wr_addr_q == OFS_FUNC_SEL);

  // Function select; only the low field is kept
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      func_sel_q <= FUNC_SEL_RST;
    end else if (sel_write) begin
      func_sel_q <= hwdata_i[SEL_W-1:0];
    end
  end

  // Upper threshold
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_q <= UPPER_RST[VALUE_W-1:0];
    end else if (wr_commit && wr_addr_q == OFS_UPPER) begin
      upper_q <= hwdata_i[VALUE_W-1:0];
    end
  end

  // Lower threshold; no ordering check against upper is made in hardware
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lower_q <= LOWER_RST[VALUE_W-1:0];
    end else if (wr_commit && wr_addr_q == OFS_LOWER) begin
      lower_q <= hwdata_i[VALUE_W-1:0];       // Band order left to software
    end
  end

  // ====================
  // Read path
  // ====================
  logic [31:0] rd_data;                           // Value for the coming data phase
  logic [31:0] status_word;                       // Live status packed
  logic        band_q;                            // Hysteresis latch
  logic        band_d;                            // Next hysteresis latch
  logic        cond_raw;                          // Selected condition now

  // Widen a threshold-sized value into a bus word
  function automatic logic [31:0] widen(input logic [VALUE_W-1:0] v);
    logic [31:0] w;
    w          = '0;
    w[VALUE_W-1:0] = v;
    widen      = w;
  endfunction

  always_comb begin
    status_word                 = '0;
    status_word[STAT_RELAY_BIT] = relay_q;
    status_word[STAT_BAND_BIT]  = band_q;
    status_word[STAT_COND_BIT]  = cond_raw;
  end

  // A read right behind a write to the same word sees the new data
  always_comb begin
    rd_data = '0;
    case (addr_lo)
      OFS_FUNC_SEL: rd_data[SEL_W-1:0] = func_sel_q;
      OFS_UPPER:    rd_data = widen(upper_q);
      OFS_LOWER:    rd_data = widen(lower_q);
      OFS_STATUS:   rd_data = status_word;
      default:      rd_data = '0;              // Unmapped reads return zero
    endcase
    if (wr_commit && wr_addr_q == addr_lo) begin
      case (addr_lo)
        OFS_FUNC_SEL: rd_data = {{(32-SEL_W){1'b0}}, hwdata_i[SEL_W-1:0]};
        OFS_UPPER:    rd_data = widen(hwdata_i[VALUE_W-1:0]);
        OFS_LOWER:    rd_data = widen(hwdata_i[VALUE_W-1:0]);
        default:      rd_data = rd_data;       // Status is read-only
      endcase
    end
  end

  // Read data registered at the end of the address phase
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_valid && !hwrite_i) begin
      hrdata_o <= rd_data;
    end
  end

  // Never stalls and never errors; held in flops so outputs stay registered
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // ====================
  // Derived drive conditions
  // ====================
  logic healthy;                                  // Powered with no fault
  logic at_target;                                // Output matches set-point
  logic freq_nonzero;                             // Output frequency above zero
  logic auto_avail;                               // Ready for automatic control
  logic safety_ok;                                // Both safety channels present

  assign healthy      = power_ok_i && !fault_i;
  assign at_target    = (out_freq_i == setpoint_freq_i);
  assign freq_nonzero = (out_freq_i != '0);
  assign auto_avail   = auto_mode_i && !trip_active_i && auto_ready_i;
  assign safety_ok    = (&hardware_safety_enable_i) && drive_operable_i;

  // ====================
  // Condition and quantity selection
  // ====================
  logic [VALUE_W-1:0] monitored;                  // Quantity under comparison
  logic               thresh_mode;                // Current select uses thresholds

  assign thresh_mode = uses_threshold(func_sel_q);

  relay_condition_select #(
    .VALUE_W        (VALUE_W)
  ) u_select (
    .sel_i          (func_sel_q),
    .running_i      (motor_running_i),
    .healthy_i      (healthy),
    .at_target_i    (at_target),
    .freq_nonzero_i (freq_nonzero),
    .pump_i         (direct_online_assist_pump_i),
    .override_i     (emergency_override_i),
    .maint_i        (maintenance_due_i),
    .auto_avail_i   (auto_avail),
    .tripped_i      (tripped_i),
    .safety_i       (safety_ok),
    .speed_i        (motor_speed_i),
    .current_i      (motor_current_i),
    .torque_i       (motor_torque_i),
    .analog2_i      (analog_in2_i),
    .pid_err_i      (pid_error_i),
    .monitored_o    (monitored),
    .cond_o         (cond_raw)
  );

  // ====================
  // Hysteresis comparator
  // ====================
  // Rewriting the select drops the latch so an old band never leaks into
  // the new quantity; the cost is one cycle of open contact when a threshold select is rewritten
  relay_hysteresis #(
    .VALUE_W    (VALUE_W)
  ) u_band (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .enable_i   (thresh_mode),
    .clear_i    (sel_write),
    .value_i    (monitored),
    .upper_i    (upper_q),
    .lower_i    (lower_q),
    .active_d_o (band_d),
    .active_q_o (band_q)
  );

  // ====================
  // Relay drive
  // ====================
  // The next band state feeds the relay directly, so every mode has the same
  // one-cycle latency from input to contact
  always_comb begin
    if (thresh_mode) begin
      relay_d = band_d;
    end else begin
      relay_d = cond_raw;
    end
  end

  // Contact closed while the chosen condition holds, open in reset
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      relay_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
    end
  end

  assign relay_contact_closed_o = relay_q;

  // hsize is accepted as is; only whole words are issued by the master
  logic unused_ok;                                // Collects deliberately unread bits
  assign unused_ok = ^{hsize_i, haddr_i[31:ADDR_W]};

endmodule

// *** relay_contact_model.sv ***
// Behavioural model of the equipment that senses the relay two contact
module relay_contact_model (
  input  wire logic relay_drive_i,       // Coil drive from the selector
  output logic      terminals_linked_o   // Both contact terminals joined
);
  // ====================
  // Contact
  // ====================
  // Closed contact links the two terminals; an open one leaves them apart
  assign terminals_linked_o = relay_drive_i;
endmodule

// *** relay_ofs_properties.sv ***
// Concurrent checks on the relay two selector ports
module relay_ofs_properties
  import relay_pkg::*;
#(
  parameter int unsigned VALUE_W = 16
) (
  input wire logic               core_clk_i, rstn_i, hsel_i, hwrite_i, hready_i,
  input wire logic [31:0]        haddr_i, hwdata_i,
  input wire logic [1:0]         htrans_i, hardware_safety_enable_i,
  input wire logic               hreadyout_o, hresp_o, relay_contact_closed_o,
  input wire logic               motor_running_i, power_ok_i, fault_i, tripped_i, drive_operable_i,
  input wire logic [VALUE_W-1:0] out_freq_i, setpoint_freq_i, motor_speed_i
);
  // ====================
  // Bus mirror of the writable registers
  // ====================
  logic               wr_pend_q;  // Write data phase under way
  logic [1:0]         wr_idx_q;   // Word index of that write
  logic [SEL_W-1:0]   sel_q;      // Mirrored function select
  logic [VALUE_W-1:0] up_q;       // Mirrored upper threshold
  logic [VALUE_W-1:0] lo_q;       // Mirrored lower threshold
  wire                sel_wr = wr_pend_q && (wr_idx_q == 2'd0);  // Select rewrite drops the band latch
  // Mirror only, so relations below can name the active select
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 2'd0;
      sel_q     <= '0;
      up_q      <= '0;
      lo_q      <= '0;
    end else if (hready_i) begin
      wr_pend_q <= hsel_i && hwrite_i && htrans_i[1] && (haddr_i[11:4] == 8'h00);
      wr_idx_q  <= haddr_i[3:2];
      if (sel_wr) sel_q <= hwdata_i[SEL_W-1:0];
      if (wr_pend_q && wr_idx_q == 2'd1) up_q <= hwdata_i[VALUE_W-1:0];
      if (wr_pend_q && wr_idx_q == 2'd2) lo_q <= hwdata_i[VALUE_W-1:0];
    end
  end
  // ====================
  // Assertions
  // ====================
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_reset_open: assert property (disable iff (1'b0) !rstn_i |-> !relay_contact_closed_o)
    else $error("closed in reset");
  chk_running_sel: assert property (sel_q == 4'h0 |=> relay_contact_closed_o == $past(motor_running_i))
    else $error("running mismatch");
  chk_healthy_sel: assert property (sel_q == 4'h1 |=>
    relay_contact_closed_o == ($past(power_ok_i) && !$past(fault_i)))
    else $error("healthy mismatch");
  chk_target_sel: assert property (sel_q == 4'h2 |=>
    relay_contact_closed_o == ($past(out_freq_i) == $past(setpoint_freq_i)))
    else $error("target mismatch");
  chk_nonzero_sel: assert property (sel_q == 4'h3 |=> relay_contact_closed_o == ($past(out_freq_i) != '0))
    else $error("nonzero mismatch");
  chk_tripped_sel: assert property (sel_q == 4'hC |=> relay_contact_closed_o == $past(tripped_i))
    else $error("tripped mismatch");
  chk_safety_sel: assert property (sel_q == 4'hD |=>
    relay_contact_closed_o == (&$past(hardware_safety_enable_i) && $past(drive_operable_i)))
    else $error("safety mismatch");
  // A select rewrite drops the band, so the set check skips that edge
  chk_speed_set: assert property (sel_q == 4'h4 && !sel_wr && motor_speed_i > up_q |=> relay_contact_closed_o)
    else $error("no set above upper");
  chk_speed_drop: assert property (sel_q == 4'h4 && motor_speed_i < lo_q && motor_speed_i <= up_q
    |=> !relay_contact_closed_o)
    else $error("no release below lower");
  chk_unused_open: assert property (sel_q == 4'hF |=> !relay_contact_closed_o)
    else $error("closed on unused code");
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready okay");
endmodule
bind relay_output_function_select relay_ofs_properties #(.VALUE_W(VALUE_W)) u_relay_ofs_properties (.*);

// *** test_relay_output_function_select.sv ***
// Self-checking bench for the relay two function selector
module test_relay_output_function_select;
  timeunit 1ns;
  timeprecision 1ps;
  import relay_pkg::*;
  localparam int unsigned VALUE_W = 16;
  logic core_clk_i, rstn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, relay_contact_closed_o, linked;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]  htrans_i, hardware_safety_enable_i;
  logic [2:0]  hsize_i;
  logic motor_running_i, power_ok_i, fault_i, direct_online_assist_pump_i, emergency_override_i;
  logic maintenance_due_i, auto_mode_i, trip_active_i, auto_ready_i, tripped_i, drive_operable_i;
  logic [VALUE_W-1:0] out_freq_i, setpoint_freq_i, motor_speed_i, motor_current_i, motor_torque_i;
  logic [VALUE_W-1:0] analog_in2_i, pid_error_i;
  wire hready_i = hreadyout_o;  // Single slave closes the ready loop
  int n_errors = 0;
  int n_tests = 0;
  relay_output_function_select #(.VALUE_W(VALUE_W)) u_relay_output_function_select (.*);
  relay_contact_model u_relay_contact_model (.relay_drive_i(relay_contact_closed_o), .terminals_linked_o(linked));
  // ====================
  // Tasks
  // ====================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    hsel_i <= 1'b1; haddr_i <= {20'h0_0000, a}; hwrite_i <= wr; htrans_i <= HTRANS_NONSEQ;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'b00; hsel_i <= 1'b0; hwdata_i <= d;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask
  // Bit k of b makes true the condition of code k for k below 4, of code k+4 from k 4 up
  task automatic apply(input logic [9:0] b, input logic neg);
    @(posedge core_clk_i);
    motor_running_i <= b[0]; power_ok_i <= b[1]; fault_i <= neg; trip_active_i <= neg;
    out_freq_i <= b[3] ? 16'h0010 : 16'h0000;
    setpoint_freq_i <= (b[3] ? 16'h0010 : 16'h0000) + {15'h0000, !b[2]};
    direct_online_assist_pump_i <= b[4]; emergency_override_i <= b[5]; maintenance_due_i <= b[6];
    auto_mode_i <= b[7]; auto_ready_i <= b[7]; tripped_i <= b[8];
    hardware_safety_enable_i <= {2{b[9]}}; drive_operable_i <= b[9];
  endtask
  // Own quantity k gets v, all other monitored quantities get o
  task automatic vals(input int k, input logic [15:0] v, input logic [15:0] o);
    @(posedge core_clk_i);
    motor_speed_i <= (k == 0) ? v : o; motor_current_i <= (k == 1) ? v : o;
    motor_torque_i <= (k == 2) ? v : o; analog_in2_i <= (k == 3) ? v : o; pid_error_i <= (k == 4) ? v : o;
  endtask
  // Relay answers one edge late; two edges leave margin
  task automatic settle(input logic exp);
    repeat (2) @(posedge core_clk_i);
    #1;
    check("relay", relay_contact_closed_o, exp);
    check("contact", linked, exp);
  endtask
  // ====================
  // Clock, watchdog and main sequence
  // ====================
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #50000;
    n_errors++;
    end_sim;
  end
  initial begin
    rstn_i = 1'b1;  // Falls at 1 ns so every flop sees a real reset edge
    {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    hsize_i = 3'd2;
    {motor_running_i, power_ok_i, fault_i, direct_online_assist_pump_i, emergency_override_i} = '0;
    {maintenance_due_i, auto_mode_i, trip_active_i, auto_ready_i, tripped_i, drive_operable_i} = '0;
    {out_freq_i, setpoint_freq_i, motor_speed_i, motor_current_i, motor_torque_i} = '0;
    {analog_in2_i, pid_error_i, hardware_safety_enable_i} = '0;
    #1 rstn_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 20; a += 4) begin
      bus(1'b0, a[11:0], 32'h0000_0000);
      check("reset value", rd, 32'h0000_0000);
    end
    for (int k = 0; k < 10; k++) begin
      bus(1'b1, OFS_FUNC_SEL, (k < 4) ? k : k + 4);  // Codes 0-3 and 8-13
      apply(10'h001 << k, 1'b0); settle(1'b1);
      apply(~(10'h001 << k), 1'b0); settle(1'b0);
      apply(10'h001 << k, 1'b1); settle(!(k == 1 || k == 7));
    end
    bus(1'b1, OFS_FUNC_SEL, 32'hFFFF_FFFF);
    apply(10'h3FF, 1'b0); settle(1'b0);
    bus(1'b0, OFS_FUNC_SEL, 32'h0000_0000); check("select", rd, 32'h0000_000F);
    bus(1'b1, OFS_UPPER, 32'hFFFF_0064);
    bus(1'b1, OFS_LOWER, 32'hFFFF_0032);
    bus(1'b0, OFS_UPPER, 32'h0000_0000); check("upper", rd, 32'h0000_0064);
    bus(1'b0, OFS_LOWER, 32'h0000_0000); check("lower", rd, 32'h0000_0032);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, OFS_FUNC_SEL, (k < 4) ? k + 4 : 14);  // Codes 4-7 and 14
      vals(k, 16'h0064, 16'h00C8); settle(1'b0);
      vals(k, 16'h0065, 16'h0000); settle(1'b1);
      vals(k, 16'h004B, 16'h0000); settle(1'b1);
      vals(k, 16'h0031, 16'h00C8); settle(1'b0);
      vals(k, 16'h004B, 16'h0000); settle(1'b0);
    end
    vals(4, 16'h0065, 16'h0000); settle(1'b1);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check("status", rd, 32'h0000_0003);
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    #1 check("relay in reset", relay_contact_closed_o, 1'b0);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check("status after reset", rd, 32'h0000_0005);
    end_sim;
  end
endmodule
